/* File: core/cfg_tail_pkg.sv */
// Constants for the configuration header tail and watchdog block.
// Assumes a single PCI clock domain and byte-wide config accesses.
package cfg_tail_pkg;
	// ****************************************
	// Offsets
	// ****************************************
	localparam logic [7:0] OFF_CAP_PTR     = 8'h34;
	localparam logic [7:0] OFF_INT_ROUTE   = 8'h3C;
	localparam logic [7:0] OFF_INT_PIN     = 8'h3D;
	localparam logic [7:0] OFF_BURST_HINT  = 8'h3E;
	localparam logic [7:0] OFF_ACCESS_HINT = 8'h3F;
	localparam logic [7:0] OFF_TRDY_LIMIT  = 8'h40;
	localparam logic [7:0] OFF_RETRY_LIMIT = 8'h41;
	localparam logic [7:0] OFF_RELEASE_NUM = 8'h60;
	localparam logic [7:0] OFF_FRAME_TRIM  = 8'h61;
	localparam logic [7:0] OFF_WAKE_LO     = 8'h62;
	localparam logic [7:0] OFF_WAKE_HI     = 8'h63;
	// ****************************************
	// Values
	// ****************************************
	localparam logic [7:0]  CAP_PTR_VAL      = 8'hDC;
	localparam logic [7:0]  INT_ROUTE_RST    = 8'h00;
	localparam logic [7:0]  INT_PIN_VAL      = 8'h01;
	localparam logic [7:0]  BURST_HINT_FS    = 8'h01;
	localparam logic [7:0]  BURST_HINT_HS    = 8'h02;
	localparam logic [7:0]  ACCESS_HINT_FS   = 8'h2A;
	localparam logic [7:0]  ACCESS_HINT_HS   = 8'h10;
	localparam logic [7:0]  TRDY_LIMIT_RST   = 8'h00;
	localparam logic [7:0]  RETRY_LIMIT_RST  = 8'h80;
	localparam logic [7:0]  RELEASE_NUM_VAL  = 8'h20;
	localparam logic [7:0]  FRAME_TRIM_RST   = 8'h20;
	localparam logic [15:0] WAKE_MASK_RST    = 16'h001F;
	localparam int          HINT_UNIT_NS     = 250;
	localparam int          TRDY_LOW_ZEROS   = 5;
	localparam int          TRDY_CNT_W       = 13;
endpackage : cfg_tail_pkg

/* File: core/cfg_tail.sv */
// Configuration header tail: pointer, interrupt, hint bytes, two watchdogs
// and the high-speed function's extension bytes.
// Assumes the PCI target decodes config cycles into byte strobes here and
// reports bus progress (transaction start, target wait, retry) as pulses.
// Behaviour
// - Capability pointer at 34h reads DCh, read only.
// - Pointer low two bits read zero; software masks them anyway.
// - Interrupt routing byte at 3Ch, read-write, resets to 00h, stored only.
// - Interrupt pin byte at 3Dh reads 01h, meaning INTA#.
// - Hint values are in 250 ns units; zero means no demand.
// - Burst hint at 3Eh reads 01h full-speed, 02h high-speed.
// - Access hint at 3Fh reads 2Ah full-speed, 10h high-speed.
// - Target-ready limit at 40h, read-write, reset 00h, zero disables.
// - Target-ready limit is 13-bit clock count, register times 32.
// - Target wait beyond limit sets the unrecoverable-error flag.
// - Retry limit at 41h, read-write, reset 80h, zero disables.
// - Retries beyond the retry limit set the unrecoverable-error flag.
// - High-speed function maps bytes at 60h, 61h and 62h to 63h.
// - Bus release number at 60h reads 20h.
`timescale 1ns/1ps
module cfg_tail
	import cfg_tail_pkg::*;
#(
	parameter bit HIGH_SPEED = 1'b1
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Configuration byte access
	input  wire logic [7:0]  cfg_addr,
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_wdata,
	output logic      [7:0]  cfg_rdata,
	output logic             cfg_hit,
	// Bus progress from the PCI target logic
	input  wire logic        txn_start,
	input  wire logic        trdy_wait,
	input  wire logic        retry_seen,
	// Error flag and its clear from the status register write path
	input  wire logic        err_clear,
	output logic             unrecoverable_error_flag
);
	// ****************************************
	// Register file
	// ****************************************
	logic [7:0]  route_q, route_d;
	logic [7:0]  trdy_lim_q, trdy_lim_d;
	logic [7:0]  retry_lim_q, retry_lim_d;
	logic [7:0]  trim_q, trim_d;
	logic [15:0] wake_q, wake_d;

	function automatic logic hs_only(input logic [7:0] a);
		hs_only = (a == OFF_RELEASE_NUM) || (a == OFF_FRAME_TRIM) ||
			(a == OFF_WAKE_LO) || (a == OFF_WAKE_HI);
	endfunction : hs_only

	function automatic logic mapped(input logic [7:0] a);
		unique case (a)
			OFF_CAP_PTR, OFF_INT_ROUTE, OFF_INT_PIN, OFF_BURST_HINT,
			OFF_ACCESS_HINT, OFF_TRDY_LIMIT, OFF_RETRY_LIMIT:
				mapped = 1'b1;
			default:
				mapped = HIGH_SPEED && hs_only(a);
		endcase
	endfunction : mapped

	always_comb
	begin
		route_d     = route_q;
		trdy_lim_d  = trdy_lim_q;
		retry_lim_d = retry_lim_q;
		trim_d      = trim_q;
		wake_d      = wake_q;
		if (cfg_wr)
		begin
			unique case (cfg_addr)
				OFF_INT_ROUTE:   route_d = cfg_wdata;
				OFF_TRDY_LIMIT:  trdy_lim_d = cfg_wdata;
				OFF_RETRY_LIMIT: retry_lim_d = cfg_wdata;
				OFF_FRAME_TRIM:
					if (HIGH_SPEED)
						trim_d = cfg_wdata;
				OFF_WAKE_LO:
					if (HIGH_SPEED)
						wake_d[7:0] = cfg_wdata;
				OFF_WAKE_HI:
					if (HIGH_SPEED)
						wake_d[15:8] = cfg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			route_q     <= INT_ROUTE_RST;
			trdy_lim_q  <= TRDY_LIMIT_RST;
			retry_lim_q <= RETRY_LIMIT_RST;
			trim_q      <= FRAME_TRIM_RST;
			wake_q      <= WAKE_MASK_RST;
		end
		else
		begin
			route_q     <= route_d;
			trdy_lim_q  <= trdy_lim_d;
			retry_lim_q <= retry_lim_d;
			trim_q      <= trim_d;
			wake_q      <= wake_d;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] rdata_q, rdata_d;
	logic       hit_q, hit_d;

	// Hints count 250 ns units; constant per function type
	always_comb
	begin
		rdata_d = 8'h00;
		hit_d   = cfg_rd && mapped(cfg_addr);
		if (cfg_rd)
		begin
			unique case (cfg_addr)
				OFF_CAP_PTR:     rdata_d = {CAP_PTR_VAL[7:2], 2'b00};
				OFF_INT_ROUTE:   rdata_d = route_q;
				OFF_INT_PIN:     rdata_d = INT_PIN_VAL;
				OFF_BURST_HINT:
					rdata_d = HIGH_SPEED ? BURST_HINT_HS : BURST_HINT_FS;
				OFF_ACCESS_HINT:
					rdata_d = HIGH_SPEED ? ACCESS_HINT_HS : ACCESS_HINT_FS;
				OFF_TRDY_LIMIT:  rdata_d = trdy_lim_q;
				OFF_RETRY_LIMIT: rdata_d = retry_lim_q;
				OFF_RELEASE_NUM:
					rdata_d = HIGH_SPEED ? RELEASE_NUM_VAL : 8'h00;
				OFF_FRAME_TRIM:  rdata_d = HIGH_SPEED ? trim_q : 8'h00;
				OFF_WAKE_LO:     rdata_d = HIGH_SPEED ? wake_q[7:0] : 8'h00;
				OFF_WAKE_HI:     rdata_d = HIGH_SPEED ? wake_q[15:8] : 8'h00;
				default:         rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 8'h00;
			hit_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			hit_q   <= hit_d;
		end
	end

	assign cfg_rdata = rdata_q;
	assign cfg_hit   = hit_q;

	// ****************************************
	// Watchdogs
	// ****************************************
	logic [TRDY_CNT_W-1:0] trdy_cnt_q, trdy_cnt_d;
	logic [7:0]            retry_cnt_q, retry_cnt_d;
	logic                  err_q, err_d;
	logic [TRDY_CNT_W-1:0] trdy_limit;
	logic                  trdy_expire, retry_expire;

	assign trdy_limit = {trdy_lim_q, {TRDY_LOW_ZEROS{1'b0}}};

	// Strictly greater than the limit, so a wait equal to it is fine
	assign trdy_expire  = (trdy_lim_q != 8'h00) && trdy_wait &&
		(trdy_cnt_q >= trdy_limit);
	assign retry_expire = (retry_lim_q != 8'h00) && retry_seen &&
		(retry_cnt_q >= retry_lim_q);

	always_comb
	begin
		trdy_cnt_d  = trdy_cnt_q;
		retry_cnt_d = retry_cnt_q;
		if (txn_start)
		begin
			trdy_cnt_d  = '0;
			retry_cnt_d = 8'h00;
		end
		else
		begin
			// Saturate so a stuck target cannot wrap past the limit
			if (trdy_wait && (trdy_cnt_q != {TRDY_CNT_W{1'b1}}))
				trdy_cnt_d = trdy_cnt_q + 1'b1;
			if (retry_seen && (retry_cnt_q != 8'hFF))
				retry_cnt_d = retry_cnt_q + 1'b1;
		end
		// Set beats clear in the same cycle
		err_d = err_q;
		if (err_clear)
			err_d = 1'b0;
		if (trdy_expire || retry_expire)
			err_d = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			trdy_cnt_q  <= '0;
			retry_cnt_q <= 8'h00;
			err_q       <= 1'b0;
		end
		else
		begin
			trdy_cnt_q  <= trdy_cnt_d;
			retry_cnt_q <= retry_cnt_d;
			err_q       <= err_d;
		end
	end

	assign unrecoverable_error_flag = err_q;
endmodule : cfg_tail

/* File: testbench/cfg_tail_chk.sv */
// Port assertions for the config tail block.
// Assumes one clock domain and the async active-high reset.
`timescale 1ns/1ps
module cfg_tail_chk #(
	parameter bit HIGH_SPEED = 1'b1
)
(
	// Watched ports
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] cfg_addr,
	input wire logic       cfg_rd,
	input wire logic [7:0] cfg_rdata,
	input wire logic       cfg_hit,
	input wire logic       trdy_wait,
	input wire logic       retry_seen,
	input wire logic       err_clear,
	input wire logic       unrecoverable_error_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence rd(logic [7:0] a);
		cfg_rd && cfg_addr == a;
	endsequence
	cap_ptr_a: assert property (rd(8'h34) |=> cfg_hit && cfg_rdata == 8'hDC)
		else $error("pointer read wrong");
	int_pin_a: assert property (rd(8'h3D) |=> cfg_rdata == 8'h01)
		else $error("pin read wrong");
	burst_hint_a: assert property (rd(8'h3E) |=> cfg_rdata == (HIGH_SPEED ? 8'h02 : 8'h01))
		else $error("burst hint wrong");
	access_hint_a: assert property (rd(8'h3F) |=> cfg_rdata == (HIGH_SPEED ? 8'h10 : 8'h2A))
		else $error("access hint wrong");
	release_num_a: assert property (rd(8'h60) |=> cfg_hit == HIGH_SPEED && cfg_rdata == (HIGH_SPEED ? 8'h20 : 8'h00))
		else $error("release number wrong");
	idle_read_a: assert property (!cfg_rd |=> !cfg_hit && cfg_rdata == 8'h00)
		else $error("read data lingers");
	flag_sticky_a: assert property (unrecoverable_error_flag && !err_clear |=> unrecoverable_error_flag)
		else $error("flag dropped");
	flag_clear_a: assert property (err_clear && !trdy_wait && !retry_seen |=> !unrecoverable_error_flag)
		else $error("flag not cleared");
	flag_cause_a: assert property ($rose(unrecoverable_error_flag) |-> $past(trdy_wait) || $past(retry_seen))
		else $error("flag without cause");
endmodule : cfg_tail_chk
bind cfg_tail cfg_tail_chk #(.HIGH_SPEED(HIGH_SPEED)) chk_u (.clk, .rst,
	.cfg_addr, .cfg_rd, .cfg_rdata, .cfg_hit, .trdy_wait, .retry_seen,
	.err_clear, .unrecoverable_error_flag);

/* File: testbench/host_model.sv */
// Host bus model: one transaction of target waits or of retries.
// Assumes the bench pulses go for one cycle while busy is low.
`timescale 1ns/1ps
module host_model (
	// Control from the bench
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic       kind,
	input  wire logic [7:0] n,
	// Bus progress to the device
	output logic            txn_start,
	output logic            trdy_wait,
	output logic            retry_seen,
	output logic            busy
);
	logic [8:0] c_q = 9'h000;
	logic       k_q = 1'b0;
	always_ff @(posedge clk)
	begin
		txn_start <= go;
		if (go)
			k_q <= kind;
		if (go)
			c_q <= kind ? {n, 1'b0} : {1'b0, n};
		else if (c_q != 9'h000 && !txn_start)
			c_q <= c_q - 9'h001;
	end
	// Retries on odd counts, so spaced one idle cycle apart
	assign trdy_wait  = !k_q && !txn_start && c_q != 9'h000;
	assign retry_seen = k_q && !txn_start && c_q[0];
	assign busy       = txn_start || c_q != 9'h000;
endmodule : host_model

/* File: testbench/cfg_tail_test.sv */
// Self-checking bench for the config tail block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module cfg_tail_test;
	logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, n = 8'h00, cfg_rdata;
	logic clk = 1'b0, rst = 1'b1, cfg_rd = 1'b0, cfg_wr = 1'b0, go = 1'b0;
	logic err_clear = 1'b0, kind = 1'b0, rd_q = 1'b0, cfg_hit, busy;
	logic txn_start, trdy_wait, retry_seen, unrecoverable_error_flag;
	logic [8:0] notes[$];
	logic [7:0] r[12];
	int checks = 0, n_fail = 0, cyc = 0;
	localparam logic [7:0] a_tab [12] = '{8'h34, 8'h3C, 8'h3D, 8'h3E,
		8'h3F, 8'h40, 8'h41, 8'h60, 8'h61, 8'h62, 8'h63, 8'h50};
	localparam logic [7:0] e_tab [12] = '{8'hDC, 8'h00, 8'h01, 8'h02,
		8'h10, 8'h00, 8'h80, 8'h20, 8'h20, 8'h1F, 8'h00, 8'h00};
	localparam logic [11:0] rw_mask = 12'h762;
	cfg_tail dut_u (.clk, .rst, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_wdata,
		.cfg_rdata, .cfg_hit, .txn_start, .trdy_wait, .retry_seen,
		.err_clear, .unrecoverable_error_flag);
	host_model host_u (.clk, .go, .kind, .n, .txn_start, .trdy_wait,
		.retry_seen, .busy);
	initial forever #20 clk = ~clk;
	// ****************************************
	// Tasks
	// ****************************************
	task report_and_stop;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task cmp(input string s, input logic [8:0] x, input logic [8:0] y);
		checks++;
		if (x !== y)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, x, y);
		end
	endtask : cmp
	task rd_b(input logic [7:0] ad, input logic [8:0] ex);
		@(posedge clk);
		cfg_rd <= 1'b1;
		cfg_addr <= ad;
		notes.push_back(ex);
		@(posedge clk);
		cfg_rd <= 1'b0;
	endtask : rd_b
	task wr_b(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_addr <= ad;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_wr <= 1'b0;
	endtask : wr_b
	// Bounded wait, then flag check and a clear pulse
	task run(input logic k, input logic [7:0] c, input logic f);
		@(posedge clk);
		go <= 1'b1;
		kind <= k;
		n <= c;
		@(posedge clk);
		go <= 1'b0;
		repeat (600)
		begin
			@(negedge clk);
			if (!busy)
				break;
		end
		// A model that never goes idle is a hang, not a pass
		if (busy)
			n_fail++;
		cmp("flag", {8'h00, f}, {8'h00, unrecoverable_error_flag});
		@(posedge clk);
		err_clear <= 1'b1;
		@(posedge clk);
		err_clear <= 1'b0;
	endtask : run
	always @(posedge clk)
	begin
		rd_q <= cfg_rd;
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	always @(negedge clk)
		if (rd_q)
			cmp("read", notes.pop_front(), {cfg_hit, cfg_rdata});
	initial
	begin
		void'($urandom(11));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++)
			rd_b(a_tab[i], {i != 11, e_tab[i]});
		for (int i = 0; i < 12; i++)
		begin
			r[i] = 8'($urandom);
			wr_b(a_tab[i], r[i]);
		end
		for (int i = 0; i < 12; i++)
			rd_b(a_tab[i], {i != 11, rw_mask[i] ? r[i] : e_tab[i]});
		wr_b(8'h40, 8'h01);
		run(1'b0, 8'd32, 1'b0);
		run(1'b0, 8'd33, 1'b1);
		run(1'b0, 8'd20, 1'b0);
		run(1'b0, 8'd20, 1'b0);
		wr_b(8'h40, 8'h00);
		run(1'b0, 8'd255, 1'b0);
		wr_b(8'h41, 8'h02);
		run(1'b1, 8'd2, 1'b0);
		run(1'b1, 8'd3, 1'b1);
		wr_b(8'h41, 8'h00);
		run(1'b1, 8'd200, 1'b0);
		report_and_stop();
	end
endmodule : cfg_tail_test
